// File: design/cct_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cct_timer
  import cct_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic SPECIAL_MODE_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic WORD_I,
  input wire logic RD_I,
  input wire logic [3:0] PIN_I,
  output logic [15:0] RDATA_O,
  output logic [3:0] PIN_O,
  output logic [3:0] PIN_OE_O
);
  logic [7:0] mode_sel_q;
  logic [7:0] mask_q;
  logic [7:0] data_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] action_q;
  logic [7:0] edge_q;
  logic [15:0] count_q;
  logic [15:0] chval_q [NCH];
  logic [3:0] chflag_q;
  logic ovf_q;
  logic [3:0] pin_prev_q;
  logic [3:0] force_q;
  logic [3:0] match_q;
  logic [3:0] port_q;
  logic tick;
  logic en;
  logic ffc;
  logic hit;
  logic [7:0] off;
  logic [3:0] match;
  logic [3:0] capt;
  logic [3:0] force_now;
  logic cnt_acc;
  logic [15:0] rd_d;
  cct_evt_if evt_bus ();

  // Window decode over both bases.
  assign hit = (ADDR_I[11:8] == BASE_BLOCK[11:8]) || (ADDR_I[11:8] == BASE_NONBLOCK[11:8]);
  assign off = ADDR_I[7:0];
  assign en = ctrl1_q[EN_BIT];
  assign ffc = ctrl1_q[FFC_BIT];
  assign force_now = (hit && WR_I && off == OFF_FORCE) ? WDATA_I[3:0] : 4'h0;
  assign cnt_acc = hit && (WR_I || RD_I) && (off == OFF_CNT_HI || off == OFF_CNT_LO);

  // Compare match and capture edges, only while enabled.
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      match[n] = en && tick && mode_sel_q[n] && (count_q == chval_q[n]);
      capt[n] = en && !mode_sel_q[n] &&
                ((edge_q[2*n] && PIN_I[n] && !pin_prev_q[n]) ||
                 (edge_q[2*n+1] && !PIN_I[n] && pin_prev_q[n]));
    end
  end

  cct_prescaler u_pre (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .run_i(en),
    .prescale_field_i(ctrl2_q[2:0]),
    .tick_o(tick)
  );

  assign evt_bus.match = match_q;
  assign evt_bus.force_req = force_q;
  assign evt_bus.count = count_q;

  cct_out_stage u_out (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .evt(evt_bus),
    .mode_sel_i(mode_sel_q),
    .action_i(action_q),
    .mask_i(mask_q),
    .data_i(data_q),
    .port_q_o(port_q)
  );

  // Event pipeline stage feeding the output stage.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      force_q <= 4'h0;
      match_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      force_q <= force_now;
      match_q <= match;
      pin_prev_q <= PIN_I;
    end
  end

  // Control registers written by software.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      mode_sel_q <= RST_BYTE;
      mask_q <= RST_BYTE;
      data_q <= RST_BYTE;
      ctrl1_q <= RST_BYTE;
      ctrl2_q <= RST_BYTE;
      action_q <= RST_BYTE;
      edge_q <= RST_BYTE;
    end else if (hit && WR_I) begin
      unique case (off)
        OFF_MODE_SEL: mode_sel_q <= {4'h0, WDATA_I[3:0]};
        OFF_MASK: mask_q <= {4'h0, WDATA_I[3:0]};
        OFF_DATA: data_q <= {4'h0, WDATA_I[3:0]};
        OFF_CTRL1: ctrl1_q <= {WDATA_I[7], 2'b00, WDATA_I[4], 4'h0};
        OFF_CTRL2: ctrl2_q <= {5'h00, WDATA_I[2:0]};
        OFF_ACTION: action_q <= WDATA_I[7:0];
        OFF_EDGE: edge_q <= WDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Counter: steps on tick, writable only in special mode.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      count_q <= RST_WORD;
    end else if (hit && WR_I && SPECIAL_MODE_I && off == OFF_CNT_HI) begin
      if (WORD_I) begin
        count_q <= WDATA_I;
      end else begin
        count_q[15:8] <= WDATA_I[7:0];
      end
    end else if (hit && WR_I && SPECIAL_MODE_I && off == OFF_CNT_LO) begin
      count_q[7:0] <= WDATA_I[7:0];
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Channel value registers: capture or software write.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      for (int n = 0; n < NCH; n++) begin
        chval_q[n] <= RST_WORD;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (capt[n]) begin
          chval_q[n] <= count_q;
        end else if (hit && WR_I && mode_sel_q[n] && off == 8'(OFF_CHVAL0 + 2 * n)) begin
          chval_q[n] <= WORD_I ? WDATA_I : {WDATA_I[7:0], chval_q[n][7:0]};
        end else if (hit && WR_I && mode_sel_q[n] && off == 8'(OFF_CHVAL0 + 2 * n + 1)) begin
          chval_q[n][7:0] <= WDATA_I[7:0];
        end
      end
    end
  end

  // Channel flags: set wins over every clear, force suppresses the compare match set but not a capture set.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      chflag_q <= 4'h0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if ((match[n] && !force_now[n]) || capt[n]) begin
          chflag_q[n] <= 1'b1;
        end else if (hit && WR_I && off == OFF_CHFLAG && WDATA_I[n]) begin
          chflag_q[n] <= 1'b0;
        end else if (ffc && hit && off[7:1] == 7'((OFF_CHVAL0 + 2 * n) >> 1) &&
                     ((RD_I && !mode_sel_q[n]) || (WR_I && mode_sel_q[n]))) begin
          chflag_q[n] <= 1'b0;
        end
      end
    end
  end

  // Overflow flag set on wrap.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      ovf_q <= 1'b0;
    end else if (tick && count_q == 16'hFFFF) begin
      ovf_q <= 1'b1;
    end else if (hit && WR_I && off == OFF_OVFLAG && WDATA_I[OVF_BIT]) begin
      ovf_q <= 1'b0;
    end else if (ffc && cnt_acc) begin
      ovf_q <= 1'b0;
    end
  end

  // Read mux; counter read whole word at the high offset.
  always_comb begin
    rd_d = RST_WORD;
    unique case (off)
      OFF_MODE_SEL: rd_d = {8'h00, mode_sel_q};
      OFF_MASK: rd_d = {8'h00, mask_q};
      OFF_DATA: rd_d = {8'h00, data_q};
      OFF_CNT_HI: rd_d = WORD_I ? count_q : {8'h00, count_q[15:8]};
      OFF_CNT_LO: rd_d = {8'h00, count_q[7:0]};
      OFF_CTRL1: rd_d = {8'h00, ctrl1_q};
      OFF_CTRL2: rd_d = {8'h00, ctrl2_q};
      OFF_ACTION: rd_d = {8'h00, action_q};
      OFF_EDGE: rd_d = {8'h00, edge_q};
      OFF_CHFLAG: rd_d = {12'h000, chflag_q};
      OFF_OVFLAG: rd_d = {8'h00, ovf_q, 7'h00};
      OFF_PORT: rd_d = {12'h000, port_q};
      default: begin
        for (int n = 0; n < NCH; n++) begin
          if (off == 8'(OFF_CHVAL0 + 2 * n)) begin
            rd_d = WORD_I ? chval_q[n] : {8'h00, chval_q[n][15:8]};
          end else if (off == 8'(OFF_CHVAL0 + 2 * n + 1)) begin
            rd_d = {8'h00, chval_q[n][7:0]};
          end
        end
      end
    endcase
  end

  // Registered read data, zero when no read hits the window.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      RDATA_O <= RST_WORD;
    end else begin
      RDATA_O <= (hit && RD_I) ? rd_d : RST_WORD;
    end
  end

  // Pin drive: compare channels with an action or a mask bit drive their pin.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      PIN_O <= 4'h0;
      PIN_OE_O <= 4'h0;
    end else begin
      PIN_O <= port_q;
      for (int n = 0; n < NCH; n++) begin
        PIN_OE_O[n] <= mode_sel_q[n] && (mask_q[n] || action_q[2*n+:2] != 2'b00);
      end
    end
  end
endmodule : cct_timer
`default_nettype wire

// File: design/cct_pkg.sv
package cct_pkg;
  // Register offsets within the timer window.
  localparam logic [7:0] OFF_MODE_SEL = 8'hC0;
  localparam logic [7:0] OFF_FORCE = 8'hC1;
  localparam logic [7:0] OFF_MASK = 8'hC2;
  localparam logic [7:0] OFF_DATA = 8'hC3;
  localparam logic [7:0] OFF_CNT_HI = 8'hC4;
  localparam logic [7:0] OFF_CNT_LO = 8'hC5;
  localparam logic [7:0] OFF_CTRL1 = 8'hC6;
  localparam logic [7:0] OFF_ACTION = 8'hC8;
  localparam logic [7:0] OFF_EDGE = 8'hC9;
  localparam logic [7:0] OFF_CTRL2 = 8'hCB;
  localparam logic [7:0] OFF_CHFLAG = 8'hCC;
  localparam logic [7:0] OFF_OVFLAG = 8'hCD;
  localparam logic [7:0] OFF_CHVAL0 = 8'hCE;
  localparam logic [7:0] OFF_PORT = 8'hD6;
  // Address window bases.
  localparam logic [11:0] BASE_BLOCK = 12'h200;
  localparam logic [11:0] BASE_NONBLOCK = 12'h300;
  // Field positions.
  localparam int EN_BIT = 7;
  localparam int FFC_BIT = 4;
  localparam int OVF_BIT = 7;
  localparam int NCH = 4;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Output action codes.
  typedef enum logic [1:0] {ACT_OFF, ACT_TOGGLE, ACT_LOW, ACT_HIGH} cct_act_e;
endpackage : cct_pkg

// File: design/cct_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Compare events passed from the counter core to the output stage.
interface cct_evt_if;
  logic [3:0] match;
  logic [3:0] force_req;
  logic [15:0] count;
  modport src (output match, output force_req, output count);
  modport dst (input match, input force_req, input count);
endinterface : cct_evt_if
`default_nettype wire

// File: design/cct_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the clock by 2 to the power of the prescale field, tick when all selected stages are zero.
module cct_prescaler
  import cct_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [2:0] prescale_field_i,
  output logic tick_o
);
  logic [6:0] stage_q;
  logic [6:0] mask;

  // Stage mask for the selected division.
  assign mask = 7'((8'h01 << prescale_field_i) - 8'h01);

  // Free running stages, only counted while the timer runs.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      stage_q <= 7'h00;
    end else if (run_i) begin
      stage_q <= stage_q + 7'h01;
    end
  end

  // Tick fires when all selected stages are zero.
  assign tick_o = run_i && ((stage_q & mask) == 7'h00);
endmodule : cct_prescaler
`default_nettype wire

// File: design/cct_out_stage.sv
`timescale 1ns/1ps
`default_nettype none
// Applies compare actions to the channel output lines.
module cct_out_stage
  import cct_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  cct_evt_if.dst evt,
  input wire logic [7:0] mode_sel_i,
  input wire logic [7:0] action_i,
  input wire logic [7:0] mask_i,
  input wire logic [7:0] data_i,
  output logic [3:0] port_q_o
);
  logic [3:0] port_d;

  // Per channel output action, channel 3 master compare overriding.
  always_comb begin
    port_d = port_q_o;
    for (int n = 0; n < NCH; n++) begin
      if (mode_sel_i[n] && (evt.match[n] || evt.force_req[n])) begin
        unique case (cct_act_e'(action_i[2*n+:2]))
          ACT_OFF: port_d[n] = port_q_o[n];
          ACT_TOGGLE: port_d[n] = ~port_q_o[n];
          ACT_LOW: port_d[n] = 1'b0;
          ACT_HIGH: port_d[n] = 1'b1;
        endcase
      end
    end
    if (mode_sel_i[3] && (evt.match[3] || evt.force_req[3])) begin
      for (int n = 0; n < NCH; n++) begin
        if (mask_i[n]) begin
          port_d[n] = data_i[n];
        end
      end
    end
  end

  // Output data latch.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_q_o <= 4'h0;
    end else begin
      port_q_o <= port_d;
    end
  end
endmodule : cct_out_stage
`default_nettype wire

// File: bench/cct_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pad side of the timer channels.
module cct_pin_model (
  input wire logic [3:0] pin_o_i,
  input wire logic [3:0] pin_oe_i,
  input wire logic [3:0] ext_i,
  output logic [3:0] pin_i_o
);
  // Driven pads read back their own level; channel 3 is a receive line and never loops back.
  assign pin_i_o = {ext_i[3], (pin_oe_i[2:0] & pin_o_i[2:0]) | (~pin_oe_i[2:0] & ext_i[2:0])};
endmodule : cct_pin_model
`default_nettype wire

// File: bench/cct_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the timer.
module cct_timer_asserts
  import cct_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic SPECIAL_MODE_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic WORD_I,
  input wire logic RD_I,
  input wire logic [3:0] PIN_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [3:0] PIN_O,
  input wire logic [3:0] PIN_OE_O
);
  logic [7:0] mode_q;
  logic en_q;
  wire logic hit = (ADDR_I[11:8] == 4'h2) || (ADDR_I[11:8] == 4'h3);
  wire logic bw = WR_I && hit;
  // Shadow of the mode register.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) mode_q <= 8'h00;
    else if (bw && ADDR_I[7:0] == OFF_MODE_SEL) mode_q <= WDATA_I[7:0];
  end
  // Shadow of the enable bit.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) en_q <= 1'b0;
    else if (bw && ADDR_I[7:0] == OFF_CTRL1) en_q <= WDATA_I[EN_BIT];
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_rd_idle; !$past(RD_I) |-> RDATA_O == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_force_rd; $past(RD_I && hit && ADDR_I[7:0] == OFF_FORCE) |-> RDATA_O == 16'h0000; endproperty
  a_force_rd: assert property (p_force_rd) else $error("force register read not zero");
  property p_rst; !$past(NRST_I) |-> PIN_O == 4'h0 && PIN_OE_O == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_pin_hold;
    $changed(PIN_O) |-> $past(WR_I, 2) || $past(WR_I, 3) || en_q || $past(en_q) || $past(en_q, 2) || $past(en_q, 3);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin moved while timer off");
  property p_oe_mode; (PIN_OE_O & ~(mode_q[3:0] | $past(mode_q[3:0]) | $past(mode_q[3:0], 2))) == 4'h0; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("pin driven in capture mode");
  property p_mode_rd;
    $past(RD_I && hit && !WORD_I && ADDR_I[7:0] == OFF_MODE_SEL) |-> RDATA_O[3:0] == $past(mode_q[3:0]);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  property p_ctrl_rd; $past(RD_I && hit && !WORD_I && ADDR_I[7:0] == OFF_CTRL1) |-> RDATA_O[7] == $past(en_q); endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("enable readback wrong");
  property p_unmapped; $past(RD_I && !hit) |-> RDATA_O == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_force: cover property (WR_I && hit && ADDR_I[7:0] == OFF_FORCE);
  c_pin: cover property ($changed(PIN_O));
  c_unmapped: cover property (RD_I && !hit);
endmodule : cct_timer_asserts
bind cct_timer cct_timer_asserts cct_timer_asserts_i (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
  .SPECIAL_MODE_I(SPECIAL_MODE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .WORD_I(WORD_I),
  .RD_I(RD_I), .PIN_I(PIN_I), .RDATA_O(RDATA_O), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O));
`default_nettype wire

// File: bench/cct_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the timer control core.
module cct_timer_tb;
  import cct_pkg::*;
  logic clk = 1'b0;
  logic nrst_n = 1'b0;
  logic spec = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic word = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] ext = 4'h8;
  wire logic [15:0] rdata;
  wire logic [3:0] pin_o;
  wire logic [3:0] pin_oe;
  wire logic [3:0] pin_i;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] v;
  logic [15:0] c;
  logic [1:0] codes [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
  logic exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  // Clock at 20 MHz.
  initial forever #25 clk = ~clk;
  cct_timer cct_timer_i (.REF_CLK_I(clk), .NRST_I(nrst_n), .SPECIAL_MODE_I(spec), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .WORD_I(word), .RD_I(rd), .PIN_I(pin_i), .RDATA_O(rdata),
    .PIN_O(pin_o), .PIN_OE_O(pin_oe));
  cct_pin_model cct_pin_model_i (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .pin_i_o(pin_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] off, input logic [15:0] d, input logic w);
    @(posedge clk);
    addr <= {4'h2, off};
    wdata <= d;
    word <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    word <= 1'b0;
  endtask : wr_reg
  task automatic rd_at(input logic [11:0] a, input logic w);
    @(posedge clk);
    addr <= a;
    word <= w;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    word <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_at
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Counter and control come up cleared.
  task automatic t_reset;
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    chk(v, RST_WORD);
    rd_at({4'h2, OFF_CTRL1}, 1'b0);
    chk(v, 16'h0000);
  endtask : t_reset
  // Toggle, high and low action codes applied by forced compares on channel 0.
  task automatic t_force;
    wr_reg(OFF_MODE_SEL, 16'h000F, 1'b0);
    rd_at({4'h2, OFF_MODE_SEL}, 1'b0);
    chk(v, 16'h000F);
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFF_ACTION, {14'h0000, codes[i]}, 1'b0);
      wr_reg(OFF_FORCE, 16'h0001, 1'b0);
      settle();
      chk({15'h0000, pin_o[0]}, {15'h0000, exps[i]});
      chk({15'h0000, pin_oe[0]}, 16'h0001);
    end
    wr_reg(OFF_ACTION, 16'h0000, 1'b0);
    settle();
    chk({15'h0000, pin_oe[0]}, 16'h0000);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h000F, 16'h0000);
  endtask : t_force
  // Channel 3 match copies masked data to the pins; flag clearing with and without fast clear.
  task automatic t_oc3;
    wr_reg(OFF_MASK, 16'h0003, 1'b0);
    wr_reg(OFF_DATA, 16'h0002, 1'b0);
    wr_reg(OFF_ACTION, 16'h0008, 1'b0);
    wr_reg(OFF_CHVAL0 + 8'h02, 16'h0008, 1'b1);
    wr_reg(OFF_CHVAL0 + 8'h06, 16'h0008, 1'b1);
    wr_reg(OFF_CTRL1, 16'h0080, 1'b0);
    repeat (30) @(posedge clk);
    wr_reg(OFF_CTRL1, 16'h0000, 1'b0);
    settle();
    chk({14'h0000, pin_o[1:0]}, 16'h0002);
    chk({14'h0000, pin_oe[1:0]}, 16'h0003);
    rd_at({4'h2, OFF_PORT}, 1'b0);
    chk(v & 16'h0003, 16'h0002);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h0008, 16'h0008);
    wr_reg(OFF_CHVAL0 + 8'h06, 16'h0008, 1'b1);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h0008, 16'h0008);
    wr_reg(OFF_CTRL1, 16'h0010, 1'b0);
    wr_reg(OFF_CHVAL0 + 8'h06, 16'h0008, 1'b1);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h0008, 16'h0000);
    wr_reg(OFF_MODE_SEL, 16'h0000, 1'b0);
    settle();
    chk({14'h0000, pin_oe[1:0]}, 16'h0000);
  endtask : t_oc3
  // Counter writes, prescaled counting, wrap and overflow flag.
  task automatic t_count;
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    c = v;
    wr_reg(OFF_CNT_HI, 16'h1234, 1'b1);
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    chk(v, c);
    @(posedge clk);
    spec <= 1'b1;
    wr_reg(OFF_CNT_HI, 16'hFFF0, 1'b1);
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    chk(v, 16'hFFF0);
    wr_reg(OFF_CTRL2, 16'h0002, 1'b0);
    wr_reg(OFF_CTRL1, 16'h0080, 1'b0);
    repeat (100) @(posedge clk);
    wr_reg(OFF_CTRL1, 16'h0000, 1'b0);
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    c = v - 16'hFFF0;
    chk({15'h0000, c >= 16'd23 && c <= 16'd27}, 16'h0001);
    repeat (20) @(posedge clk);
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    chk(v - 16'hFFF0, c);
    rd_at({4'h2, OFF_OVFLAG}, 1'b0);
    chk(v & 16'h0080, 16'h0080);
    wr_reg(OFF_CTRL1, 16'h0010, 1'b0);
    rd_at({4'h2, OFF_CNT_HI}, 1'b1);
    rd_at({4'h2, OFF_OVFLAG}, 1'b0);
    chk(v & 16'h0080, 16'h0000);
    @(posedge clk);
    spec <= 1'b0;
  endtask : t_count
  // Capture on channel 2, and a force landing on a real match of channel 0.
  task automatic t_capt;
    @(posedge clk);
    spec <= 1'b1;
    wr_reg(OFF_MODE_SEL, 16'h0001, 1'b0);
    wr_reg(OFF_CHVAL0, 16'h0101, 1'b1);
    wr_reg(OFF_CNT_HI, 16'h0100, 1'b1);
    wr_reg(OFF_CTRL2, 16'h0000, 1'b0);
    wr_reg(OFF_EDGE, 16'h0010, 1'b0);
    wr_reg(OFF_CHFLAG, 16'h000F, 1'b0);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h000F, 16'h0000);
    wr_reg(OFF_CTRL1, 16'h0090, 1'b0);
    wr_reg(OFF_FORCE, 16'h0001, 1'b0);
    repeat (3) @(posedge clk);
    ext[2] <= 1'b1;
    @(posedge clk);
    wr_reg(OFF_CTRL1, 16'h0010, 1'b0);
    ext <= 4'h8;
    spec <= 1'b0;
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h000F, 16'h0004);
    rd_at({4'h2, OFF_CHVAL0 + 8'h04}, 1'b1);
    chk(v, 16'h0105);
    rd_at({4'h2, OFF_CHFLAG}, 1'b0);
    chk(v & 16'h000F, 16'h0000);
  endtask : t_capt
  // Both address windows, an unmapped address and the write-only force register.
  task automatic t_map;
    rd_at({BASE_NONBLOCK[11:8], OFF_CTRL1}, 1'b0);
    chk(v & 16'h00FF, 16'h0010);
    rd_at({4'h1, OFF_CTRL1}, 1'b0);
    chk(v, 16'h0000);
    rd_at({4'h2, OFF_FORCE}, 1'b0);
    chk(v, 16'h0000);
  endtask : t_map
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    nrst_n <= 1'b1;
    t_reset();
    t_force();
    t_oc3();
    t_count();
    t_capt();
    t_map();
    finish_test();
  end
  // Watchdog well beyond the expected run.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : cct_timer_tb
`default_nettype wire
